// ### verilog/mrc_pkg.sv
// shared constants for the memory interface reset and calibration block
package mrc_pkg;
  // core clock rate
  localparam int CLK_MHZ = 40;
  // least time the interface is held in reset before recalibration
  localparam int RST_HOLD_NS = 250;
  localparam int RST_HOLD_CYC = (RST_HOLD_NS * CLK_MHZ + 999) / 1000;
  // longest wait for the calibration engine before declaring failure
  localparam int CAL_TIMEOUT_US = 1000;
  localparam int CAL_TIMEOUT_CYC = CAL_TIMEOUT_US * CLK_MHZ;
  // least request pulse width, in core clock cycles
  localparam int REQ_MIN_CYC = 2;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;

  // control register fields
  localparam int CTRL_REQ_BIT = 0;
  // status register fields
  localparam int ST_DONE_BIT = 0;
  localparam int ST_PASS_BIT = 1;
  localparam int ST_FAIL_BIT = 2;
  localparam int ST_BUSY_BIT = 3;
  // interrupt status and mask fields
  localparam int IRQ_W = 4;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_PASS_BIT = 1;
  localparam int IRQ_FAIL_BIT = 2;
  localparam int IRQ_DROP_BIT = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

  // sequencer states
  typedef enum logic [1:0] {
    MRC_ST_RESET,
    MRC_ST_CAL,
    MRC_ST_DONE
  } mrc_state_t;
endpackage

// ### verilog/mrc_req_capture.sv
// catches the unconstrained reset request and turns its rise into a pulse
`timescale 1ns/100ps
module mrc_req_capture (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_async_i,
  output logic pulse_o
);
  // first stage is read only by the second; edge found on stages 2 and 3
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic pulse_reg;
  wire logic rise_w;

  assign rise_w = s2_reg & ~s3_reg;
  assign pulse_o = pulse_reg;

  // a pulse of two cycles always lands in s1 at least once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      pulse_reg <= 1'b0;
    end else begin
      s1_reg <= req_async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      pulse_reg <= rise_w;
    end
  end
endmodule

// ### verilog/mrc_rst_sync.sv
// reset bridge: asserts at once, releases on the target clock
`timescale 1ns/100ps
module mrc_rst_sync (
  input wire logic clk_i,
  input wire logic arst_n_i,
  output logic rst_n_o
);
  logic meta_reg;
  logic out_reg;

  assign rst_n_o = out_reg;

  // async clear to constant, two-stage release
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_reg <= 1'b0;
      out_reg <= 1'b0;
    end else begin
      meta_reg <= 1'b1;
      out_reg <= meta_reg;
    end
  end
endmodule

// ### verilog/mrc_top.sv
// reset sequencer, calibration status and wishbone registers
//
// What this block does
// - catch request unconstrained, any two-cycle pulse
// - request in idle resets interface then fully recalibrates; one while busy is dropped
// - reset done stays low during reset
// - done high: sequence over, out, ready
// - pass output high on successful calibration
// - fail output high on failed calibration
// - phy reset: async assert, sync release
// - column reset resets and recalibrates interface
// - user reset: async assert, sync release
`timescale 1ns/100ps
module mrc_top #(
  parameter int CAL_TIMEOUT = mrc_pkg::CAL_TIMEOUT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic col_rst_n_i, // column-wide reset, async, low
  input wire logic reset_req_i, // user reset request, unconstrained
  output logic reset_done_o,
  output logic cal_pass_o,
  output logic cal_fail_o,
  output logic cal_start_o, // one-cycle kick to calibration engine
  input wire logic cal_done_i, // engine finished
  input wire logic cal_ok_i, // engine result, valid with cal_done_i
  input wire logic phy_clk_i,
  output logic phy_rst_n_o,
  input wire logic usr_clk_i,
  output logic usr_rst_n_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o
);
  localparam int IW = mrc_pkg::IRQ_W;

  // sequencer state
  mrc_pkg::mrc_state_t state_reg;
  mrc_pkg::mrc_state_t state_next;
  logic [7:0] hold_reg; // reset hold down-counter
  logic [31:0] cal_cnt_reg; // calibration watchdog
  logic in_reset_reg; // interface held in reset
  logic pass_reg;
  logic fail_reg;
  logic start_reg;
  // column reset, synchronised for the sequencer only
  logic col_m_reg;
  logic col_s_reg;
  // bus and interrupt state
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [IW-1:0] irq_stat_reg;
  logic [IW-1:0] irq_mask_reg;
  logic sw_req_reg; // software request, one cycle

  wire logic hw_req_w;
  wire logic any_req_w;
  wire logic accept_w;
  wire logic cal_end_w;
  wire logic timeout_w;
  wire logic result_ok_w;
  wire logic dom_arst_n_w;

  // request input capture
  mrc_req_capture u_req (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req_async_i(reset_req_i),
    .pulse_o(hw_req_w)
  );

  assign any_req_w = hw_req_w | sw_req_reg;
  // only taken once the previous sequence has completed
  assign accept_w = any_req_w & (state_reg == mrc_pkg::MRC_ST_DONE);
  assign timeout_w = cal_cnt_reg == 32'(CAL_TIMEOUT - 1);
  assign cal_end_w = (state_reg == mrc_pkg::MRC_ST_CAL) &
                     (cal_done_i | timeout_w);
  // a timeout counts as a failed calibration
  assign result_ok_w = cal_done_i & cal_ok_i;

  // next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      mrc_pkg::MRC_ST_RESET: begin
        if (hold_reg == 8'h00 && col_s_reg) begin
          state_next = mrc_pkg::MRC_ST_CAL;
        end
      end
      mrc_pkg::MRC_ST_CAL: begin
        if (cal_end_w) begin
          state_next = mrc_pkg::MRC_ST_DONE;
        end
      end
      mrc_pkg::MRC_ST_DONE: begin
        if (accept_w) begin
          state_next = mrc_pkg::MRC_ST_RESET;
        end
      end
      default: begin
        state_next = mrc_pkg::MRC_ST_RESET;
      end
    endcase
    // column reset overrides everything
    if (!col_s_reg) begin
      state_next = mrc_pkg::MRC_ST_RESET;
    end
  end

  // column reset synchroniser, second stage is the only reader of first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      col_m_reg <= 1'b0;
      col_s_reg <= 1'b0;
    end else begin
      col_m_reg <= col_rst_n_i;
      col_s_reg <= col_m_reg;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= mrc_pkg::MRC_ST_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // reset hold counter, reloaded on every entry to reset
  always_ff @(posedge clk_i) begin
    if (rst_i || state_reg != mrc_pkg::MRC_ST_RESET) begin
      hold_reg <= 8'(mrc_pkg::RST_HOLD_CYC - 1);
    end else if (hold_reg != 8'h00) begin
      hold_reg <= hold_reg - 8'h01;
    end
  end

  // calibration watchdog, guards against an engine that never answers
  always_ff @(posedge clk_i) begin
    if (rst_i || state_reg != mrc_pkg::MRC_ST_CAL) begin
      cal_cnt_reg <= 32'h0000_0000;
    end else if (!timeout_w) begin
      cal_cnt_reg <= cal_cnt_reg + 32'h0000_0001;
    end
  end

  // interface reset level and calibration kick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_reset_reg <= 1'b1;
      start_reg <= 1'b0;
    end else begin
      in_reset_reg <= state_next == mrc_pkg::MRC_ST_RESET;
      start_reg <= (state_reg == mrc_pkg::MRC_ST_RESET) &&
                   (state_next == mrc_pkg::MRC_ST_CAL);
    end
  end

  // result flags: cleared in reset and calibration, one set at the end
  always_ff @(posedge clk_i) begin
    if (rst_i || state_next != mrc_pkg::MRC_ST_DONE) begin
      pass_reg <= 1'b0;
      fail_reg <= 1'b0;
    end else if (cal_end_w) begin
      pass_reg <= result_ok_w;
      fail_reg <= ~result_ok_w;
    end
  end

  assign reset_done_o = (state_reg == mrc_pkg::MRC_ST_DONE) &
                        ~in_reset_reg;
  assign cal_pass_o = pass_reg;
  assign cal_fail_o = fail_reg;
  assign cal_start_o = start_reg;

  // domain resets follow the interface reset and the column reset
  assign dom_arst_n_w = col_rst_n_i & ~in_reset_reg;

  mrc_rst_sync u_phy_rst (
    .clk_i(phy_clk_i),
    .arst_n_i(dom_arst_n_w),
    .rst_n_o(phy_rst_n_o)
  );

  mrc_rst_sync u_usr_rst (
    .clk_i(usr_clk_i),
    .arst_n_i(dom_arst_n_w),
    .rst_n_o(usr_rst_n_o)
  );

  // wishbone decode; a write lands on the edge where ack is high
  wire logic req_w;
  wire logic wr_w;
  wire logic sel_ctrl_w;
  wire logic sel_stat_w;
  wire logic sel_istat_w;
  wire logic sel_imask_w;
  wire logic [IW-1:0] irq_set_w;
  wire logic [IW-1:0] irq_clr_w;
  wire logic [31:0] rd_mux_w;
  wire logic [3:0] status_w;

  assign req_w = wb_cyc_i & wb_stb_i;
  assign wr_w = req_w & wb_we_i & ack_reg & wb_sel_i[0];
  assign sel_ctrl_w = wb_adr_i == mrc_pkg::CTRL_OFS;
  assign sel_stat_w = wb_adr_i == mrc_pkg::STATUS_OFS;
  assign sel_istat_w = wb_adr_i == mrc_pkg::IRQ_STAT_OFS;
  assign sel_imask_w = wb_adr_i == mrc_pkg::IRQ_MASK_OFS;

  assign status_w[mrc_pkg::ST_DONE_BIT] = reset_done_o;
  assign status_w[mrc_pkg::ST_PASS_BIT] = pass_reg;
  assign status_w[mrc_pkg::ST_FAIL_BIT] = fail_reg;
  assign status_w[mrc_pkg::ST_BUSY_BIT] = in_reset_reg |
                                        (state_reg == mrc_pkg::MRC_ST_CAL);

  // unmapped offsets and the control register read as zero
  assign rd_mux_w = sel_stat_w ? {28'h0000000, status_w} :
                    sel_istat_w ? {28'h0000000, irq_stat_reg} :
                    sel_imask_w ? {28'h0000000, irq_mask_reg} :
                    32'h0000_0000;

  // events: done, pass, fail, and a request that was not accepted
  assign irq_set_w[mrc_pkg::IRQ_DONE_BIT] = cal_end_w;
  assign irq_set_w[mrc_pkg::IRQ_PASS_BIT] = cal_end_w & result_ok_w;
  assign irq_set_w[mrc_pkg::IRQ_FAIL_BIT] = cal_end_w & ~result_ok_w;
  assign irq_set_w[mrc_pkg::IRQ_DROP_BIT] = any_req_w & ~accept_w;
  assign irq_clr_w = (wr_w && sel_istat_w) ? wb_dat_i[IW-1:0] : '0;

  // single-cycle answer, ack drops the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req_w & ~ack_reg;
      dat_reg <= rd_mux_w;
    end
  end

  // control and interrupt registers; set wins over write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_req_reg <= 1'b0;
      irq_stat_reg <= '0;
      irq_mask_reg <= mrc_pkg::IRQ_MASK_RST;
    end else begin
      sw_req_reg <= wr_w & sel_ctrl_w & wb_dat_i[mrc_pkg::CTRL_REQ_BIT];
      irq_stat_reg <= (irq_stat_reg & ~irq_clr_w) | irq_set_w;
      if (wr_w && sel_imask_w) begin
        irq_mask_reg <= wb_dat_i[IW-1:0];
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  // ack as seen on the port, declared ahead of the check that reads it
  wire logic ack_o_chk;
  assign ack_o_chk = ack_reg;

  // checks on the sequencer and the bus slave
  AST_REQ_TAKEN: assert property (
    @(posedge clk_i) disable iff (rst_i)
    hw_req_w && state_reg == mrc_pkg::MRC_ST_DONE |=> !reset_done_o)
    else $error("request in idle did not start a reset");
  AST_RST_LOW: assert property (
    @(posedge clk_i) disable iff (rst_i)
    in_reset_reg |-> !reset_done_o)
    else $error("reset done high while in reset");
  AST_DONE_CAUSE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $rose(reset_done_o) |-> $past(cal_end_w))
    else $error("reset done rose without calibration end");
  AST_PASS: assert property (
    @(posedge clk_i) disable iff (rst_i)
    cal_end_w && result_ok_w && col_s_reg |=> cal_pass_o && !cal_fail_o)
    else $error("pass not reported");
  AST_FAIL: assert property (
    @(posedge clk_i) disable iff (rst_i)
    cal_end_w && !result_ok_w && col_s_reg |=> cal_fail_o && !cal_pass_o)
    else $error("fail not reported");
  AST_EXCL: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (in_reset_reg |-> !cal_pass_o && !cal_fail_o) and
    (reset_done_o |-> cal_pass_o ^ cal_fail_o))
    else $error("calibration results inconsistent");
  // every entry to reset is held for the full ten-cycle hold
  AST_HOLD: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $rose(in_reset_reg) |-> in_reset_reg [*8] ##1 in_reset_reg [*2])
    else $error("reset hold too short");
  AST_RECAL: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $fell(in_reset_reg) |-> cal_start_o ##1 !cal_start_o)
    else $error("no calibration after reset");
  AST_COLUMN: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !col_s_reg |=> in_reset_reg && !reset_done_o)
    else $error("column reset ignored");
  AST_ACK: assert property (
    @(posedge clk_i) disable iff (rst_i)
    req_w && !ack_reg |=> ack_o_chk)
    else $error("bus not answered in one cycle");
endmodule

// ### tb/mrc_cal_model.sv
// behavioural calibration engine facing the sequencer
`timescale 1ns/100ps
module mrc_cal_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i, // kick from the sequencer
  input wire logic [7:0] delay_i, // cycles to answer, 0 = never
  input wire logic ok_i, // result to report
  output logic done_o,
  output logic ok_o
);
  logic [7:0] cnt_reg; // remaining cycles, 0 when idle
  // result line toggles outside done so a stale value never looks valid
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 8'h00;
      done_o <= 1'b0;
      ok_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      ok_o <= ~ok_o;
      if (start_i && delay_i != 8'h00) begin
        cnt_reg <= delay_i;
      end else if (cnt_reg == 8'h01) begin
        done_o <= 1'b1;
        ok_o <= ok_i;
        cnt_reg <= 8'h00;
      end else if (cnt_reg != 8'h00) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end
endmodule

// ### tb/testbench.sv
// self-checking bench for the reset and calibration block
`timescale 1ns/100ps
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic col_rst_n = 1'b1;
  logic req = 1'b0;
  logic phy_clk = 1'b0;
  logic usr_clk = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0;
  logic done, pass, fail, start, eng_done, eng_res;
  logic phy_rst_n, usr_rst_n, wb_ack, irq;
  logic [31:0] rd_dat, q;
  logic [7:0] eng_dly = 8'h05; // engine answer time
  logic eng_ok = 1'b1;
  int n_fail = 0;
  int n_tests = 0;

  always #12.5 clk_i = ~clk_i;
  always #4 phy_clk = ~phy_clk; // unrelated domain clocks
  always #9 usr_clk = ~usr_clk;

  // short timeout keeps the silent-engine case brief
  mrc_top #(.CAL_TIMEOUT(50)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .col_rst_n_i(col_rst_n), .reset_req_i(req), .reset_done_o(done),
    .cal_pass_o(pass), .cal_fail_o(fail), .cal_start_o(start),
    .cal_done_i(eng_done), .cal_ok_i(eng_res), .phy_clk_i(phy_clk),
    .phy_rst_n_o(phy_rst_n), .usr_clk_i(usr_clk), .usr_rst_n_o(usr_rst_n),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(rd_dat), .wb_ack_o(wb_ack), .irq_o(irq));

  mrc_cal_model eng (.clk_i(clk_i), .rst_i(rst_i), .start_i(start),
    .delay_i(eng_dly), .ok_i(eng_ok), .done_o(eng_done), .ok_o(eng_res));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one classic wishbone cycle; read data lands in q
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    int k;
    k = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    wb_sel <= 4'hf;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack !== 1'b1 && k < 20);
    if (wb_ack !== 1'b1) begin
      n_fail++;
      give_verdict();
    end
    q = rd_dat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clk_i);
  endtask

  // bounded wait for the reset-complete level
  task automatic wait_for(input logic lvl);
    int k;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (done !== lvl && k < 400);
    if (done !== lvl) begin
      n_fail++;
      give_verdict();
    end
  endtask

  // shortest legal request pulse
  task automatic pulse_req;
    req <= 1'b1;
    repeat (2) @(posedge clk_i);
    req <= 1'b0;
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_for(1'b1);
    check({30'h0, fail, pass}, 32'h1);
    check({30'h0, usr_rst_n, phy_rst_n}, 32'h3);
    wb(1'b0, mrc_pkg::STATUS_OFS, 32'h0);
    check(q, 32'h3);
    wb(1'b0, 8'h40, 32'h0);
    check(q, 32'h0); // unmapped reads zero
    wb(1'b0, mrc_pkg::IRQ_MASK_OFS, 32'h0);
    check(q, 32'h0); // mask resets clear
    wb(1'b0, mrc_pkg::IRQ_STAT_OFS, 32'h0);
    check(q, 32'h3); // done and pass events recorded
    check({31'h0, irq}, 32'h0); // masked events stay quiet
    wb(1'b1, mrc_pkg::IRQ_MASK_OFS, 32'h1);
    check({31'h0, irq}, 32'h1); // unmasked event raises irq
    wb(1'b1, mrc_pkg::IRQ_STAT_OFS, 32'h1);
    check({31'h0, irq}, 32'h0); // write-one clears only bit 0
    wb(1'b0, mrc_pkg::IRQ_STAT_OFS, 32'h0);
    check(q, 32'h2);
    wb(1'b1, mrc_pkg::IRQ_STAT_OFS, 32'h2);
    // hardware request, failing engine, second request while busy
    eng_ok <= 1'b0;
    pulse_req();
    wait_for(1'b0);
    check({30'h0, fail, pass}, 32'h0);
    check({30'h0, usr_rst_n, phy_rst_n}, 32'h0);
    pulse_req();
    wait_for(1'b1);
    check({30'h0, fail, pass}, 32'h2);
    wb(1'b0, mrc_pkg::STATUS_OFS, 32'h0);
    check(q, 32'h5);
    wb(1'b0, mrc_pkg::IRQ_STAT_OFS, 32'h0);
    check(q, 32'hd); // dropped request flagged
    wb(1'b1, mrc_pkg::IRQ_STAT_OFS, 32'hf);
    // software request, engine never answers
    eng_dly <= 8'h00;
    eng_ok <= 1'b1;
    wb(1'b1, mrc_pkg::CTRL_OFS, 32'h1);
    wait_for(1'b0);
    wb(1'b0, mrc_pkg::STATUS_OFS, 32'h0);
    check(q, 32'h8);
    wait_for(1'b1);
    check({30'h0, fail, pass}, 32'h2);
    // column reset, engine passes again
    eng_dly <= 8'h03;
    col_rst_n <= 1'b0;
    @(posedge clk_i);
    check({30'h0, usr_rst_n, phy_rst_n}, 32'h0);
    wait_for(1'b0);
    check({30'h0, fail, pass}, 32'h0);
    col_rst_n <= 1'b1;
    wait_for(1'b1);
    check({30'h0, fail, pass}, 32'h1);
    give_verdict();
  end
endmodule
